// *** bench/lcsb_host_model.sv ***
// Host processor model driving the byte-wide register port of the bank
`timescale 1ns/1ps
module lcsb_host_model (
  // Clock
  input  wire logic       core_clk,
  // Register port towards the bank
  output logic      [7:0] host_addr,
  output logic            host_wr,
  output logic            host_rd,
  output logic      [7:0] host_wdata,
  input  wire logic [7:0] host_rdata,
  input  wire logic       host_rdata_valid
);
  // Idle port until the first request
  initial {host_addr, host_wr, host_rd, host_wdata} = 18'h0;
  // One-cycle write pulse, no answer expected
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    {host_addr, host_wdata, host_wr} = {a, d, 1'b1};
    @(posedge core_clk) #1;
    host_wr = 1'b0;
  endtask
  // One-cycle read pulse; answer and strobe taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge core_clk) #1;
    {host_addr, host_rd} = {a, 1'b1};
    @(posedge core_clk) #1;
    host_rd = 1'b0;
    {v, d} = {host_rdata_valid, host_rdata};
  endtask
endmodule // lcsb_host_model

// *** bench/lcsb_status_bank_tb_top.sv ***
// Self-checking testbench for the link charger status bank
`timescale 1ns/1ps
module lcsb_status_bank_tb_top;
  logic       core_clk, sys_rst;                  // Clock and reset
  logic [7:0] host_addr, host_wdata, host_rdata;  // Register port
  logic       host_wr, host_rd, host_rdata_valid; // Register strobes
  logic [7:0] st;                                 // Presence inputs by bit
  logic [2:0] flt;                                // Fault inputs
  logic [7:0] res1, res2, mv;                     // Result codes, mirror value
  logic       stb1, stb2;                         // Result strobes
  logic [7:0] ctl [0:6];                          // Control register outputs
  logic [7:0] pchg;                               // Presence change pulses
  logic [2:0] fchg;                               // Fault change pulses
  logic [3:0] cirq;                               // Command finished/failed pulses
  int         miscompares = 0;
  int         n_tests = 0;
  ////////////////////////////////////////////////////////////////////////////
  lcsb_host_model i_host (.core_clk(core_clk), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid));
  lcsb_status_bank i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid),
    .config_loaded_in(st[7]), .chan1_connected(st[6]), .chan2_connected(st[5]), .chan1_remote_idle(st[4]),
    .chan2_remote_idle(st[3]), .chan2_wet_flag(st[1]), .chan1_wet_flag(st[0]), .converter_undervolt(flt[2]),
    .converter_fault(flt[1]), .thermal_fault(flt[0]), .chan1_result(res1), .chan1_result_strobe(stb1),
    .chan2_result(res2), .chan2_result_strobe(stb2), .remote1_avg_in(mv), .remote1_level_in(mv),
    .remote2_avg_in(mv), .remote2_level_in(mv), .remote_ready_in(mv), .in_res_in(mv), .adc_avg_in(mv),
    .adc_max_in(mv), .adc_min_in(mv), .adc_ground_threshold_retry(ctl[0]), .adc_range_select(ctl[1]),
    .adc_averaging_count(ctl[2]), .adc_noise_control(ctl[3]), .wet_detect_multiplier(ctl[4]),
    .wet_detect_threshold(ctl[5]), .wet_detect_control(ctl[6]), .presence_change_irq(pchg),
    .fault_change_irq(fchg), .chan1_cmd_finished_irq(cirq[3]), .chan1_cmd_failed_irq(cirq[2]),
    .chan2_cmd_finished_irq(cirq[1]), .chan2_cmd_failed_irq(cirq[0]));
  ////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read one register, expecting an answer strobe and a value
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_host.rd(a, d, v);
    chk({7'h0, v}, 8'h01);
    chk(d, exp);
  endtask
  // Reset values of status, result and fault registers
  task automatic t_reset();
    rdchk(8'h01, 8'h80);
    rdchk(8'h02, 8'h00);
    rdchk(8'h03, 8'h00);
    rdchk(8'h04, 8'h00);
    rdchk(8'h00, 8'h5a);
  endtask
  // Each presence flag but the load flag alone: its bit position and its change pulse
  task automatic t_flags();
    int bl[6] = '{6, 5, 4, 3, 1, 0};
    foreach (bl[i]) begin
      @(posedge core_clk) #1;
      st[bl[i]] = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk(pchg, 8'h01 << bl[i]);
      rdchk(8'h01, 8'h80 | (8'h01 << bl[i]));
      st[bl[i]] = 1'b0;
    end
    repeat (3) @(posedge core_clk);
  endtask
  // Each fault flag alone: its bit position and its change pulse
  task automatic t_faults();
    for (int b = 0; b < 3; b++) begin
      @(posedge core_clk) #1;
      flt = 3'h1 << b;
      repeat (2) @(posedge core_clk);
      #1 chk({5'h0, fchg}, 8'h01 << b);
      rdchk(8'h04, 8'h20 << b);
      flt = 3'h0;
    end
    repeat (3) @(posedge core_clk);
  endtask
  // Every result code on both channels at once, read after the pulse
  task automatic t_results();
    logic [7:0] c[5] = '{8'h00, 8'h10, 8'h13, 8'h16, 8'h17};
    foreach (c[i]) begin
      @(posedge core_clk) #1;
      {res1, res2, stb1, stb2} = {c[i], c[4-i], 2'b11};
      @(posedge core_clk) #1;
      {stb1, stb2} = 2'b00;
      chk({4'h0, cirq}, {4'h0, c[i] == 0, c[i] != 0, c[4-i] == 0, c[4-i] != 0});
      rdchk(8'h02, c[i]);
      rdchk(8'h03, c[4-i]);
    end
    i_host.wr(8'h02, 8'hff);
    rdchk(8'h02, 8'h17);
    i_host.wr(8'h03, 8'hff);
    rdchk(8'h03, lcsb_pkg::RESULT_OK);
  endtask
  // Control writes, masking, read-only and unmapped places, mirrors
  task automatic t_control();
    logic [7:0] ca[7] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76};
    logic [7:0] cm[7] = '{lcsb_pkg::MASK_ADC_GND, lcsb_pkg::MASK_ADC_RANGE, lcsb_pkg::MASK_ADC_AVG,
                          lcsb_pkg::MASK_ADC_NOISE, lcsb_pkg::MASK_WET_MULT, lcsb_pkg::MASK_WET_THR,
                          lcsb_pkg::MASK_WET_CTRL};
    logic [7:0] ma[6] = '{8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h7a, 8'h7b};
    // Every control register: all ones in, writable field out and read back
    foreach (ca[i]) begin
      i_host.wr(ca[i], 8'hff);
      chk(ctl[i], cm[i]);
      rdchk(ca[i], cm[i]);
    end
    i_host.wr(8'h75, 8'h3c);
    chk(ctl[5], 8'h3c);
    i_host.wr(8'h70, 8'hff);
    chk(ctl[0], 8'h7f);
    i_host.wr(8'h01, 8'h00);
    rdchk(8'h01, 8'h80);
    rdchk(8'h77, 8'h00);
    rdchk(8'h79, 8'ha5);
    rdchk(8'h6f, 8'h85);
    rdchk(8'h78, mv & lcsb_pkg::MASK_IN_RES);
    // Remaining mirrors pass their input through whole
    foreach (ma[i]) rdchk(ma[i], mv);
  endtask
  // Load flag low: change pulse, then reads and writes refused
  task automatic t_not_ready();
    logic [7:0] d;
    logic       v;
    @(posedge core_clk) #1;
    st[7] = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk(pchg, 8'h80);
    i_host.rd(8'h01, d, v);
    chk({7'h0, v}, 8'h00);
    i_host.wr(8'h75, 8'h11);
    chk(ctl[5], 8'h3c);
    st[7] = 1'b1;
    repeat (3) @(posedge core_clk);
    rdchk(8'h01, 8'h80);
  endtask
  // Verdict and end of run
  task automatic results();
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Reset, then the scenarios in order
  initial begin
    {sys_rst, st, flt, res1, res2, stb1, stb2, mv} = {1'b1, 8'h80, 3'h0, 16'h0, 2'b0, 8'ha5};
    repeat (12) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    t_reset();
    t_flags();
    t_faults();
    t_results();
    t_control();
    t_not_ready();
    results();
  end
  // Watchdog well beyond the fewer than 200 cycles the tests need
  initial begin
    #50us;
    miscompares++;
    results();
  end
endmodule // lcsb_status_bank_tb_top

// *** src/lcsb_change_detect.sv ***
// Edge detector turning status flag transitions into change-interrupt pulses
`timescale 1ns/1ps
module lcsb_change_detect (
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   sys_rst,
  // Status snapshots in, change pulses out
  lcsb_flag_if.detect flags
);

  // Held state of the detector
  typedef struct packed {
    logic [7:0] prev_presence;  // Presence seen last cycle
    logic [2:0] prev_faults;    // Faults seen last cycle
    logic [7:0] presence_chg;   // Presence change pulses
    logic [2:0] fault_chg;      // Fault change pulses
  } lcsb_det_s;

  lcsb_det_s state;
  lcsb_det_s next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Compare against last snapshot; bit two has no flag behind it
  always_comb begin
    next_state               = state;
    next_state.prev_presence = flags.presence;
    next_state.prev_faults   = flags.faults;
    next_state.presence_chg  = (flags.presence ^ state.prev_presence) & 8'hfb;
    next_state.fault_chg     = flags.faults ^ state.prev_faults;
  end

  // Register the detector state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state.prev_presence <= lcsb_pkg::RST_PRESENCE;
      state.prev_faults   <= lcsb_pkg::RST_FAULTS;
      state.presence_chg  <= 8'h00;
      state.fault_chg     <= 3'h0;
    end else begin
      state <= next_state;
    end
  end

  assign flags.presence_chg = state.presence_chg;
  assign flags.fault_chg    = state.fault_chg;

endmodule // lcsb_change_detect

// *** src/lcsb_flag_if.sv ***
// Interface carrying status snapshots and change pulses between bank and change detector
`timescale 1ns/1ps
interface lcsb_flag_if;
  logic [7:0] presence;      // Registered presence flags
  logic [2:0] faults;        // Registered fault flags, high bit is undervoltage
  logic [7:0] presence_chg;  // One-cycle change pulses per presence bit
  logic [2:0] fault_chg;     // One-cycle change pulses per fault bit

  modport bank (output presence, output faults, input presence_chg, input fault_chg);
  modport detect (input presence, input faults, output presence_chg, output fault_chg);
endinterface

// *** src/lcsb_pkg.sv ***
// Package of offsets, field positions, reset values and codes for the link charger status bank
package lcsb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_REVISION     = 8'h00;  // Silicon revision
  localparam logic [7:0] OFF_PRESENCE     = 8'h01;  // Link presence flags
  localparam logic [7:0] OFF_CHAN1_RESULT = 8'h02;  // Channel one result code
  localparam logic [7:0] OFF_CHAN2_RESULT = 8'h03;  // Channel two result code
  localparam logic [7:0] OFF_POWER_FAULT  = 8'h04;  // Power fault flags
  localparam logic [7:0] OFF_R1_AVG       = 8'h6b;  // Remote one average value
  localparam logic [7:0] OFF_R1_LEVEL     = 8'h6c;  // Remote one charge level
  localparam logic [7:0] OFF_R2_AVG       = 8'h6d;  // Remote two average value
  localparam logic [7:0] OFF_R2_LEVEL     = 8'h6e;  // Remote two charge level
  localparam logic [7:0] OFF_REMOTE_RDY   = 8'h6f;  // Remote ready flags
  localparam logic [7:0] OFF_ADC_GND      = 8'h70;  // Ground threshold and retry
  localparam logic [7:0] OFF_ADC_RANGE    = 8'h71;  // Range select
  localparam logic [7:0] OFF_ADC_AVG_NUM  = 8'h72;  // Averaging count
  localparam logic [7:0] OFF_ADC_NOISE    = 8'h73;  // Noise control
  localparam logic [7:0] OFF_WET_MULT     = 8'h74;  // Wet detect multiplier
  localparam logic [7:0] OFF_WET_THR      = 8'h75;  // Wet detect threshold
  localparam logic [7:0] OFF_WET_CTRL     = 8'h76;  // Wet detect control
  localparam logic [7:0] OFF_IN_RES       = 8'h78;  // Input resistance result
  localparam logic [7:0] OFF_ADC_AVG      = 8'h79;  // ADC average result
  localparam logic [7:0] OFF_ADC_MAX      = 8'h7a;  // ADC maximum result
  localparam logic [7:0] OFF_ADC_MIN      = 8'h7b;  // ADC minimum result

  ////////////////////////////////////////////////////////////////////////////
  // Presence flag bit positions
  localparam int BIT_CFG_LOADED = 7;  // Configuration load complete
  localparam int BIT_C1_CONN    = 6;  // Channel one connected
  localparam int BIT_C2_CONN    = 5;  // Channel two connected
  localparam int BIT_C1_IDLE    = 4;  // Channel one remote idle
  localparam int BIT_C2_IDLE    = 3;  // Channel two remote idle
  localparam int BIT_C2_WET     = 1;  // Channel two moisture
  localparam int BIT_C1_WET     = 0;  // Channel one moisture

  // Power fault bit positions
  localparam int BIT_UNDERVOLT  = 7;  // Converter output undervoltage
  localparam int BIT_CONV_FAULT = 6;  // General converter fault
  localparam int BIT_THERMAL    = 5;  // Thermal fault

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_PRESENCE = 8'h80;  // Load complete reads one
  localparam logic [7:0] RST_RESULT   = 8'h00;  // No error
  localparam logic [2:0] RST_FAULTS   = 3'h0;   // No faults
  localparam logic [7:0] RST_CONFIG   = 8'h00;  // Control registers

  // Writable field masks of the control registers, then read masks of two mirrors
  localparam logic [7:0] MASK_ADC_GND   = 8'h7f;
  localparam logic [7:0] MASK_ADC_RANGE = 8'h3f;
  localparam logic [7:0] MASK_ADC_AVG   = 8'h07;
  localparam logic [7:0] MASK_ADC_NOISE = 8'h3f;
  localparam logic [7:0] MASK_WET_MULT  = 8'h03;
  localparam logic [7:0] MASK_WET_THR   = 8'hff;
  localparam logic [7:0] MASK_WET_CTRL  = 8'hff;
  localparam logic [7:0] MASK_READY     = 8'hcf;  // Remote ready flags
  localparam logic [7:0] MASK_IN_RES    = 8'h03;  // Resistance result

  ////////////////////////////////////////////////////////////////////////////
  // Result codes
  localparam logic [7:0] RESULT_OK             = 8'h00;
  localparam logic [7:0] RESULT_REFUSED        = 8'h10;
  localparam logic [7:0] RESULT_UNKNOWN_CMD    = 8'h13;
  localparam logic [7:0] RESULT_COMMAND_FAULT  = 8'h16;
  localparam logic [7:0] RESULT_RETRY_EXHAUST  = 8'h17;

  // Any code other than no-error counts as a failed command
  function automatic logic result_failed(input logic [7:0] code);
    result_failed = (code != RESULT_OK);
  endfunction

endpackage

// *** src/lcsb_status_bank.sv ***
// Host-visible status bank of a two-channel charging-and-data link master
`timescale 1ns/1ps
module lcsb_status_bank #(
  parameter logic [7:0] REVISION = 8'h5a  // Arbitrary revision value
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Host register port
  input  wire logic [7:0] host_addr,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic [7:0] host_wdata,
  output logic      [7:0] host_rdata,
  output logic            host_rdata_valid,
  // Status from link and protection logic
  input  wire logic       config_loaded_in,
  input  wire logic       chan1_connected,
  input  wire logic       chan2_connected,
  input  wire logic       chan1_remote_idle,
  input  wire logic       chan2_remote_idle,
  input  wire logic       chan1_wet_flag,
  input  wire logic       chan2_wet_flag,
  input  wire logic       converter_undervolt,
  input  wire logic       converter_fault,
  input  wire logic       thermal_fault,
  // Command results from link logic
  input  wire logic [7:0] chan1_result,
  input  wire logic       chan1_result_strobe,
  input  wire logic [7:0] chan2_result,
  input  wire logic       chan2_result_strobe,
  // Gauge mirrors and moisture measurement results
  input  wire logic [7:0] remote1_avg_in,
  input  wire logic [7:0] remote1_level_in,
  input  wire logic [7:0] remote2_avg_in,
  input  wire logic [7:0] remote2_level_in,
  input  wire logic [7:0] remote_ready_in,
  input  wire logic [7:0] in_res_in,
  input  wire logic [7:0] adc_avg_in,
  input  wire logic [7:0] adc_max_in,
  input  wire logic [7:0] adc_min_in,
  // Moisture measurement settings
  output logic      [7:0] adc_ground_threshold_retry,
  output logic      [7:0] adc_range_select,
  output logic      [7:0] adc_averaging_count,
  output logic      [7:0] adc_noise_control,
  output logic      [7:0] wet_detect_multiplier,
  output logic      [7:0] wet_detect_threshold,
  output logic      [7:0] wet_detect_control,
  // Event pulses towards the interrupt flag registers
  output logic      [7:0] presence_change_irq,
  output logic      [2:0] fault_change_irq,
  output logic            chan1_cmd_finished_irq,
  output logic            chan1_cmd_failed_irq,
  output logic            chan2_cmd_finished_irq,
  output logic            chan2_cmd_failed_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Held state of the bank
  typedef struct packed {
    logic [7:0] presence;      // Presence flags
    logic [7:0] chan1_code;    // Channel one result code
    logic [7:0] chan2_code;    // Channel two result code
    logic [2:0] faults;        // Undervoltage, converter, thermal
    logic [7:0] r1_avg;        // Remote gauge mirrors
    logic [7:0] r1_level;
    logic [7:0] r2_avg;
    logic [7:0] r2_level;
    logic [7:0] r_ready;
    logic [7:0] in_res;        // Measurement results
    logic [7:0] a_avg;
    logic [7:0] a_max;
    logic [7:0] a_min;
    logic [7:0] c_gnd;         // Control registers
    logic [7:0] c_range;
    logic [7:0] c_avg;
    logic [7:0] c_noise;
    logic [7:0] c_mult;
    logic [7:0] c_thr;
    logic [7:0] c_wet;
    logic [7:0] rdata;         // Read answer
    logic       rvalid;        // Read answer strobe
    logic [3:0] cmd_irq;       // c1 done, c1 fail, c2 done, c2 fail
  } lcsb_bank_s;

  lcsb_bank_s state;
  lcsb_bank_s next_state;

  lcsb_flag_if flag_bus ();  // Link to change detector
  logic        bus_open;     // Host access allowed

  ////////////////////////////////////////////////////////////////////////////
  // Change detector for presence and fault flags
  lcsb_change_detect u_detect (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .flags    (flag_bus.detect)
  );

  assign flag_bus.presence = state.presence;
  assign flag_bus.faults   = state.faults;
  assign bus_open          = state.presence[lcsb_pkg::BIT_CFG_LOADED];

  ////////////////////////////////////////////////////////////////////////////
  // Next state: sample status, latch results, serve host
  always_comb begin
    next_state = state;
    // Whole-register snapshot each cycle
    next_state.presence = {config_loaded_in, chan1_connected, chan2_connected,
                           chan1_remote_idle, chan2_remote_idle, 1'b0,
                           chan2_wet_flag, chan1_wet_flag};
    next_state.faults   = {converter_undervolt, converter_fault, thermal_fault};
    next_state.r1_avg   = remote1_avg_in;
    next_state.r1_level = remote1_level_in;
    next_state.r2_avg   = remote2_avg_in;
    next_state.r2_level = remote2_level_in;
    next_state.r_ready  = remote_ready_in & lcsb_pkg::MASK_READY;
    next_state.in_res   = in_res_in & lcsb_pkg::MASK_IN_RES;
    next_state.a_avg    = adc_avg_in;
    next_state.a_max    = adc_max_in;
    next_state.a_min    = adc_min_in;
    // Result codes load on their strobe and announce done or failed
    next_state.cmd_irq  = 4'h0;
    if (chan1_result_strobe) begin
      next_state.chan1_code = chan1_result;
      next_state.cmd_irq[3] = !lcsb_pkg::result_failed(chan1_result);
      next_state.cmd_irq[2] = lcsb_pkg::result_failed(chan1_result);
    end
    if (chan2_result_strobe) begin
      next_state.chan2_code = chan2_result;
      next_state.cmd_irq[1] = !lcsb_pkg::result_failed(chan2_result);
      next_state.cmd_irq[0] = lcsb_pkg::result_failed(chan2_result);
    end
    // Host writes reach only control registers
    if (host_wr && bus_open) begin
      case (host_addr)
        lcsb_pkg::OFF_ADC_GND:     next_state.c_gnd   = host_wdata & lcsb_pkg::MASK_ADC_GND;
        lcsb_pkg::OFF_ADC_RANGE:   next_state.c_range = host_wdata & lcsb_pkg::MASK_ADC_RANGE;
        lcsb_pkg::OFF_ADC_AVG_NUM: next_state.c_avg   = host_wdata & lcsb_pkg::MASK_ADC_AVG;
        lcsb_pkg::OFF_ADC_NOISE:   next_state.c_noise = host_wdata & lcsb_pkg::MASK_ADC_NOISE;
        lcsb_pkg::OFF_WET_MULT:    next_state.c_mult  = host_wdata & lcsb_pkg::MASK_WET_MULT;
        lcsb_pkg::OFF_WET_THR:     next_state.c_thr   = host_wdata & lcsb_pkg::MASK_WET_THR;
        lcsb_pkg::OFF_WET_CTRL:    next_state.c_wet   = host_wdata & lcsb_pkg::MASK_WET_CTRL;
        default: ;
      endcase
    end
    // Host reads answer one cycle later; unmapped reads zero
    next_state.rvalid = host_rd && bus_open;
    if (host_rd && bus_open) begin
      case (host_addr)
        lcsb_pkg::OFF_REVISION:     next_state.rdata = REVISION;
        lcsb_pkg::OFF_PRESENCE:     next_state.rdata = state.presence;
        lcsb_pkg::OFF_CHAN1_RESULT: next_state.rdata = state.chan1_code;
        lcsb_pkg::OFF_CHAN2_RESULT: next_state.rdata = state.chan2_code;
        lcsb_pkg::OFF_POWER_FAULT:  next_state.rdata = {state.faults, 5'h00};
        lcsb_pkg::OFF_R1_AVG:       next_state.rdata = state.r1_avg;
        lcsb_pkg::OFF_R1_LEVEL:     next_state.rdata = state.r1_level;
        lcsb_pkg::OFF_R2_AVG:       next_state.rdata = state.r2_avg;
        lcsb_pkg::OFF_R2_LEVEL:     next_state.rdata = state.r2_level;
        lcsb_pkg::OFF_REMOTE_RDY:   next_state.rdata = state.r_ready;
        lcsb_pkg::OFF_ADC_GND:      next_state.rdata = state.c_gnd;
        lcsb_pkg::OFF_ADC_RANGE:    next_state.rdata = state.c_range;
        lcsb_pkg::OFF_ADC_AVG_NUM:  next_state.rdata = state.c_avg;
        lcsb_pkg::OFF_ADC_NOISE:    next_state.rdata = state.c_noise;
        lcsb_pkg::OFF_WET_MULT:     next_state.rdata = state.c_mult;
        lcsb_pkg::OFF_WET_THR:      next_state.rdata = state.c_thr;
        lcsb_pkg::OFF_WET_CTRL:     next_state.rdata = state.c_wet;
        lcsb_pkg::OFF_IN_RES:       next_state.rdata = state.in_res;
        lcsb_pkg::OFF_ADC_AVG:      next_state.rdata = state.a_avg;
        lcsb_pkg::OFF_ADC_MAX:      next_state.rdata = state.a_max;
        lcsb_pkg::OFF_ADC_MIN:      next_state.rdata = state.a_min;
        default:                    next_state.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register the bank state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state            <= '0;
      state.presence   <= lcsb_pkg::RST_PRESENCE;
      state.chan1_code <= lcsb_pkg::RST_RESULT;
      state.chan2_code <= lcsb_pkg::RST_RESULT;
      state.faults     <= lcsb_pkg::RST_FAULTS;
      state.c_gnd      <= lcsb_pkg::RST_CONFIG;
      state.c_range    <= lcsb_pkg::RST_CONFIG;
      state.c_avg      <= lcsb_pkg::RST_CONFIG;
      state.c_noise    <= lcsb_pkg::RST_CONFIG;
      state.c_mult     <= lcsb_pkg::RST_CONFIG;
      state.c_thr      <= lcsb_pkg::RST_CONFIG;
      state.c_wet      <= lcsb_pkg::RST_CONFIG;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign host_rdata                 = state.rdata;
  assign host_rdata_valid           = state.rvalid;
  assign adc_ground_threshold_retry = state.c_gnd;
  assign adc_range_select           = state.c_range;
  assign adc_averaging_count        = state.c_avg;
  assign adc_noise_control          = state.c_noise;
  assign wet_detect_multiplier      = state.c_mult;
  assign wet_detect_threshold       = state.c_thr;
  assign wet_detect_control         = state.c_wet;
  assign presence_change_irq        = flag_bus.presence_chg;
  assign fault_change_irq           = flag_bus.fault_chg;
  assign chan1_cmd_finished_irq     = state.cmd_irq[3];
  assign chan1_cmd_failed_irq       = state.cmd_irq[2];
  assign chan2_cmd_finished_irq     = state.cmd_irq[1];
  assign chan2_cmd_failed_irq       = state.cmd_irq[0];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_load_flag_read: assert property (host_rd && bus_open && host_addr == lcsb_pkg::OFF_PRESENCE
    |=> host_rdata[7] == $past(state.presence[7]))
    else $error("load flag read mismatch");
  a_conn_flags: assert property (1'b1 |=> state.presence[6:5] == $past({chan1_connected, chan2_connected}))
    else $error("connection flags not sampled");
  a_idle_flags: assert property (1'b1 |=> state.presence[4:3] == $past({chan1_remote_idle, chan2_remote_idle}))
    else $error("idle flags not sampled");
  a_wet_flags: assert property (1'b1 |=> state.presence[2:0] == $past({1'b0, chan2_wet_flag, chan1_wet_flag}))
    else $error("moisture flags wrong");
  a_chan1_code: assert property (chan1_result_strobe |=> state.chan1_code == $past(chan1_result)
    && (chan1_cmd_finished_irq ^ chan1_cmd_failed_irq))
    else $error("channel one result not captured");
  a_chan2_code: assert property (chan2_result_strobe |=> state.chan2_code == $past(chan2_result)
    && (chan2_cmd_finished_irq ^ chan2_cmd_failed_irq))
    else $error("channel two result not captured");
  a_code_hold: assert property (!chan1_result_strobe |=> $stable(state.chan1_code))
    else $error("result code changed without strobe");
  a_fault_read: assert property (host_rd && bus_open && host_addr == lcsb_pkg::OFF_POWER_FAULT
    |=> host_rdata == {$past(state.faults), 5'h00})
    else $error("fault register read wrong");
  a_conn_change: assert property ($changed(state.presence[6]) |=> presence_change_irq[6])
    else $error("connection change not flagged");
  a_change_quiet: assert property ($stable(state.presence) |=> presence_change_irq == 8'h00)
    else $error("spurious change pulse");
  a_bus_gate: assert property (!bus_open |=> !host_rdata_valid && $stable(state.c_thr))
    else $error("bus served before load");
  a_ready_change: assert property ($changed(state.presence[7]) |=> presence_change_irq[7])
    else $error("load flag change not flagged");
  a_fault_sync: assert property (1'b1 |=> state.faults == $past({converter_undervolt, converter_fault,
    thermal_fault}))
    else $error("fault flags not sampled whole");
  a_ro_write: assert property (host_wr && host_addr == lcsb_pkg::OFF_CHAN2_RESULT && !chan2_result_strobe
    |=> $stable(state.chan2_code))
    else $error("write altered read-only register");

  c_failed_cmd: cover property (chan1_result_strobe && chan1_result == lcsb_pkg::RESULT_RETRY_EXHAUST);
  c_connect: cover property ($rose(chan2_connected) ##2 presence_change_irq[5]);
  c_ctrl_rw: cover property (host_wr && host_addr == lcsb_pkg::OFF_WET_THR ##2 host_rd ##1 host_rdata_valid);
  c_fault: cover property ($rose(fault_change_irq[2]));

endmodule // lcsb_status_bank
